// ==== signal_mixer_consts.svh ====
`ifndef SIGNAL_MIXER_CONSTS_SVH
`define SIGNAL_MIXER_CONSTS_SVH

// ==========================================================
// select field width
`define SEL_WIDTH 4

// ==========================================================
// keying source select codes, all others connect nothing
`define KEY_SEL_SOFTWARE 4'h0
`define KEY_SEL_EXT_PIN 4'h1
`define KEY_SEL_PWM 4'h2
`define KEY_SEL_COMPARATOR 4'h6
`define KEY_SEL_SPI 4'h8
`define KEY_SEL_UART 4'ha

// ==========================================================
// carrier select codes, all others give ground
`define CAR_SEL_GROUND 4'h0
`define CAR_SEL_EXT_ONE 4'h1
`define CAR_SEL_EXT_TWO 4'h2
`define CAR_SEL_REFCLK 4'h3
`define CAR_SEL_PWM 4'h4

// ==========================================================
// reset values
`define CONTROL_RESET '0
`define RELEASE_RESET '0
`define LEVEL_RESET 1'h0

`endif

// ==== signal_mixer_pkg.sv ====
`default_nettype none
`include "signal_mixer_consts.svh"

package signal_mixer_pkg;

	// which carrier feeds the output
	typedef enum logic {
		USE_LOW = 1'b0,
		USE_HIGH = 1'b1
	} carrier_use_t;

	// software control bits
	typedef struct packed {
		logic mixer_enable;
		logic mixed_pin_output_enable;
		logic output_invert;
		logic software_keying_value;
		logic [`SEL_WIDTH-1:0] keying_source_select;
		logic keying_source_pin_disconnect;
		logic [`SEL_WIDTH-1:0] high_carrier_select;
		logic high_carrier_sync_enable;
		logic high_carrier_invert;
		logic high_carrier_pin_disconnect;
		logic [`SEL_WIDTH-1:0] low_carrier_select;
		logic low_carrier_sync_enable;
		logic low_carrier_invert;
		logic low_carrier_pin_disconnect;
	} control_t;

	// signals from on-chip peripherals and pins
	typedef struct packed {
		logic pwm_out;
		logic spi_data_out;
		logic spi_mode;
		logic comparator_out;
		logic uart_tx;
		logic refclk_out;
		logic external_keying_pin;
		logic external_carrier_pin_one;
		logic external_carrier_pin_two;
	} sources_t;

	// peripherals released from their default output pin
	typedef struct packed {
		logic pwm;
		logic spi;
		logic comparator;
		logic uart;
		logic refclk;
	} pin_release_t;

	// whole module state
	typedef struct packed {
		control_t ctrl;
		carrier_use_t active_carrier;
		logic mixed_level;
		logic keying_level;
		pin_release_t release_pins;
	} state_t;

endpackage

`default_nettype wire

// ==== signal_mixer.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "signal_mixer_consts.svh"

// How it works
// R01: output is the currently selected carrier gated by the keying state
// R02: keying high mixes the high carrier, keying low the low carrier
// R03: mixer only active while the enable bit is set
// R04: disabled: both carriers forced to ground, keying forced to software bit
// R05: disabling keeps stored selections; they act again once re-enabled
// R06: pin enable clear: mixing continues but the output pin held low
// R07: keying from pwm, spi data, comparator, uart tx, pin or software bit
// R08: four-bit field selects the keying source
// R09: carriers from pwm, reference clock, two carrier pins or ground
// R10: separate four-bit select fields for high and low carriers
// R11: with sync on, outgoing carrier pulse finishes low before switching
// R12: separate sync enables for high and low carriers
// R13: each carrier has its own polarity inversion bit
// R14: per-carrier bit releases the selected peripheral from its pin
// R15: software keying bit drives keying when selected
// R16: keying disconnect bit releases the selected keying peripheral
// R17: keying codes 0,1,2,6,8,a; every other code connects nothing
// R18: output invert bit inverts the modulated output
// R19: reset disables mixer and returns controls to defaults
// R20: with sync off, carriers swap at once on keying change
// R21: controls clocked under reset; mixing path itself is combinational
module signal_mixer (
	input wire logic clock, // system clock, 25 MHz
	input wire logic reset, // async reset, active high
	input wire logic clock_enable, // freezes all state when low
	input wire signal_mixer_pkg::control_t control, // software bits
	input wire signal_mixer_pkg::sources_t sources, // source signals
	output logic mixed_output_pin, // modulated output pin
	output logic mixed_output_status, // registered output readback
	output logic keying_status, // registered keying level
	output logic high_carrier_in_use, // registered carrier choice
	output signal_mixer_pkg::pin_release_t pin_release // pin releases
);

	// ==========================================================
	// state
	signal_mixer_pkg::state_t s_q;
	signal_mixer_pkg::state_t s_d;

	// ==========================================================
	// combinational mixing signals
	logic keying_raw;
	logic keying;
	logic high_src;
	logic low_src;
	logic high_carrier;
	logic low_carrier;
	logic out_sync_en;
	logic out_level;
	logic hold_old;
	signal_mixer_pkg::carrier_use_t target;
	signal_mixer_pkg::carrier_use_t use_now;
	logic mixed;
	logic mixed_polar;
	signal_mixer_pkg::pin_release_t release_d;

	// ==========================================================
	// keying source lookup
	function automatic logic key_pick(
		input logic [`SEL_WIDTH-1:0] sel,
		input signal_mixer_pkg::sources_t src,
		input logic sw
	);
		logic k;
		k = 1'b0;
		case (sel)
			`KEY_SEL_SOFTWARE: k = sw; // [R15]
			`KEY_SEL_EXT_PIN: k = src.external_keying_pin; // [R07]
			`KEY_SEL_PWM: k = src.pwm_out;
			`KEY_SEL_COMPARATOR: k = src.comparator_out;
			// spi data counts only while the port runs in spi mode
			`KEY_SEL_SPI: k = src.spi_data_out & src.spi_mode;
			`KEY_SEL_UART: k = src.uart_tx;
			default: k = 1'b0; // [R17]
		endcase
		return k;
	endfunction

	// ==========================================================
	// carrier source lookup, shared by both carriers
	function automatic logic car_pick(
		input logic [`SEL_WIDTH-1:0] sel,
		input signal_mixer_pkg::sources_t src
	);
		logic c;
		c = 1'b0;
		case (sel)
			`CAR_SEL_GROUND: c = 1'b0; // [R09]
			`CAR_SEL_EXT_ONE: c = src.external_carrier_pin_one;
			`CAR_SEL_EXT_TWO: c = src.external_carrier_pin_two;
			`CAR_SEL_REFCLK: c = src.refclk_out;
			`CAR_SEL_PWM: c = src.pwm_out;
			default: c = 1'b0; // unused codes read as ground
		endcase
		return c;
	endfunction

	// ==========================================================
	// source selection from the clocked control copy
	always_comb begin
		// selects are looked up every time; enable decides use
		keying_raw = key_pick(s_q.ctrl.keying_source_select, sources,
			s_q.ctrl.software_keying_value); // [R08]
		high_src = car_pick(s_q.ctrl.high_carrier_select,
			sources); // [R10]
		low_src = car_pick(s_q.ctrl.low_carrier_select,
			sources); // [R10]
		if (s_q.ctrl.mixer_enable) begin // [R03] [R05]
			keying = keying_raw;
			high_carrier = high_src ^ s_q.ctrl.high_carrier_invert; // [R13]
			low_carrier = low_src ^ s_q.ctrl.low_carrier_invert; // [R13]
		end else begin
			// parked on ground so nothing toggles while idle
			keying = s_q.ctrl.software_keying_value; // [R04]
			high_carrier = 1'b0; // [R04]
			low_carrier = 1'b0; // [R04]
		end
	end

	// ==========================================================
	// carrier switching with optional synchronisation
	always_comb begin
		target = keying ? signal_mixer_pkg::USE_HIGH
			: signal_mixer_pkg::USE_LOW; // [R02]
		case (s_q.active_carrier)
			signal_mixer_pkg::USE_HIGH: begin
				out_sync_en = s_q.ctrl.high_carrier_sync_enable; // [R12]
				out_level = high_carrier;
			end
			signal_mixer_pkg::USE_LOW: begin
				out_sync_en = s_q.ctrl.low_carrier_sync_enable; // [R12]
				out_level = low_carrier;
			end
			default: begin
				out_sync_en = 1'b0;
				out_level = 1'b0;
			end
		endcase
		// outgoing pulse still high and sync on: keep it to its end
		hold_old = (target != s_q.active_carrier) && out_sync_en
			&& out_level; // [R11]
		// without sync the swap is immediate, same cycle as keying
		use_now = hold_old ? s_q.active_carrier : target; // [R20]
	end

	// ==========================================================
	// output path, purely combinational so carriers can
	// run faster than the clock; the readback lags by a cycle
	always_comb begin
		case (use_now)
			signal_mixer_pkg::USE_HIGH: mixed = high_carrier; // [R01]
			signal_mixer_pkg::USE_LOW: mixed = low_carrier; // [R01]
			default: mixed = 1'b0;
		endcase
		mixed_polar = mixed ^ s_q.ctrl.output_invert; // [R18]
	end

	// pin held low while its enable is clear, mixing carries on
	assign mixed_output_pin = s_q.ctrl.mixed_pin_output_enable
		& mixed_polar; // [R06] [R21]

	// ==========================================================
	// pin release for each peripheral that feeds a source
	always_comb begin
		release_d = `RELEASE_RESET;
		if (s_q.ctrl.mixer_enable) begin
			if (s_q.ctrl.keying_source_pin_disconnect) begin // [R16]
				case (s_q.ctrl.keying_source_select)
					`KEY_SEL_PWM: release_d.pwm = 1'b1;
					`KEY_SEL_COMPARATOR: release_d.comparator = 1'b1;
					`KEY_SEL_SPI: release_d.spi = 1'b1;
					`KEY_SEL_UART: release_d.uart = 1'b1;
					default: ;
				endcase
			end
			if (s_q.ctrl.high_carrier_pin_disconnect) begin // [R14]
				case (s_q.ctrl.high_carrier_select)
					`CAR_SEL_PWM: release_d.pwm = 1'b1;
					`CAR_SEL_REFCLK: release_d.refclk = 1'b1;
					default: ;
				endcase
			end
			if (s_q.ctrl.low_carrier_pin_disconnect) begin // [R14]
				case (s_q.ctrl.low_carrier_select)
					`CAR_SEL_PWM: release_d.pwm = 1'b1;
					`CAR_SEL_REFCLK: release_d.refclk = 1'b1;
					default: ;
				endcase
			end
		end
	end

	// ==========================================================
	// next state
	always_comb begin
		s_d = s_q;
		if (clock_enable) begin
			// control copy taken every enabled edge
			s_d.ctrl = control; // [R21]
			s_d.active_carrier = use_now; // [R11]
			s_d.mixed_level = mixed_output_pin;
			s_d.keying_level = keying;
			s_d.release_pins = release_d;
		end
	end

	// ==========================================================
	// state register; reset clears every control bit,
	// which leaves the mixer disabled and the pin low
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			s_q.ctrl <= `CONTROL_RESET; // [R19]
			s_q.active_carrier <= signal_mixer_pkg::USE_LOW;
			s_q.mixed_level <= `LEVEL_RESET;
			s_q.keying_level <= `LEVEL_RESET;
			s_q.release_pins <= `RELEASE_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// registered status
	assign mixed_output_status = s_q.mixed_level;
	assign keying_status = s_q.keying_level;
	assign high_carrier_in_use =
		(s_q.active_carrier == signal_mixer_pkg::USE_HIGH);
	assign pin_release = s_q.release_pins;

endmodule // signal_mixer

`default_nettype wire

// ==== signal_mixer_props.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// port checks for the signal mixer
module signal_mixer_props (
	input wire logic clock, // system clock
	input wire logic reset, // async reset
	input wire logic clock_enable, // state advance
	input wire signal_mixer_pkg::control_t control, // control bits
	input wire signal_mixer_pkg::sources_t sources, // source signals
	input wire logic mixed_output_pin, // modulated pin
	input wire logic mixed_output_status, // pin readback
	input wire logic keying_status, // keying readback
	input wire logic high_carrier_in_use, // carrier readback
	input wire signal_mixer_pkg::pin_release_t pin_release // releases
);
	signal_mixer_pkg::control_t c_q;
	logic on;
	logic [3:0] ks, hs, ls;
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	// copy of the controls as the mixing path sees them
	always_ff @(posedge clock or posedge reset) begin
		if (reset) c_q <= '0;
		else if (clock_enable) c_q <= control;
	end
	// sync off keeps the mix purely combinational
	assign on = c_q.mixer_enable && c_q.mixed_pin_output_enable &&
		!c_q.high_carrier_sync_enable && !c_q.low_carrier_sync_enable;
	assign ks = c_q.keying_source_select;
	assign hs = c_q.high_carrier_select;
	assign ls = c_q.low_carrier_select;
	chk_disabled_pin: assert property (
		!c_q.mixer_enable |-> mixed_output_pin ==
		(c_q.mixed_pin_output_enable & c_q.output_invert))
		else $error("pin wrong while disabled");
	chk_pin_gate: assert property (
		c_q.mixer_enable && !c_q.mixed_pin_output_enable
		|-> mixed_output_pin == 1'b0) else $error("pin not held low");
	chk_high_mix: assert property (
		on && ks == 4'h0 && c_q.software_keying_value && hs == 4'h1
		|-> mixed_output_pin == (sources.external_carrier_pin_one ^
		c_q.high_carrier_invert ^ c_q.output_invert))
		else $error("high carrier mix wrong");
	chk_low_mix: assert property (
		on && ks == 4'h0 && !c_q.software_keying_value && ls == 4'h2
		|-> mixed_output_pin == (sources.external_carrier_pin_two ^
		c_q.low_carrier_invert ^ c_q.output_invert))
		else $error("low carrier mix wrong");
	chk_key_pin: assert property (
		on && ks == 4'h1 && hs == 4'h1 && ls == 4'h2 &&
		!c_q.high_carrier_invert && !c_q.low_carrier_invert &&
		!c_q.output_invert |-> mixed_output_pin ==
		(sources.external_keying_pin ? sources.external_carrier_pin_one
		: sources.external_carrier_pin_two)) else $error("key pin wrong");
	chk_null_code: assert property (
		on && ks == 4'h3 && ls == 4'h0 && !c_q.low_carrier_invert &&
		!c_q.output_invert |-> mixed_output_pin == 1'b0)
		else $error("reserved code keyed");
	chk_status_copy: assert property (
		clock_enable |=> mixed_output_status == $past(mixed_output_pin))
		else $error("status not a copy of pin");
	chk_freeze_hold: assert property (
		!clock_enable |=> $stable(keying_status) &&
		$stable(high_carrier_in_use)) else $error("state moved frozen");
	chk_release_off: assert property (
		(clock_enable && !control.mixer_enable)[*3]
		|-> pin_release == '0) else $error("release while disabled");
endmodule // signal_mixer_props
bind signal_mixer signal_mixer_props i_signal_mixer_props (
	.clock(clock), .reset(reset), .clock_enable(clock_enable),
	.control(control), .sources(sources),
	.mixed_output_pin(mixed_output_pin),
	.mixed_output_status(mixed_output_status),
	.keying_status(keying_status),
	.high_carrier_in_use(high_carrier_in_use),
	.pin_release(pin_release));
`default_nettype wire

// ==== line_receiver.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// far end of the pin: a listener, never drives back
module line_receiver (
	input wire logic clock, // system clock
	input wire logic reset, // async reset
	input wire logic line, // modulated line
	output logic level_q // line level at last edge
);
	// sampled, since the line may run faster than the clock
	always_ff @(posedge clock or posedge reset) begin
		if (reset) level_q <= 1'b0;
		else level_q <= line;
	end
endmodule // line_receiver
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// signal mixer bench
module tb_top;
	logic clock, reset, clock_enable, pin, st, ks, hu, seen, v;
	logic [3:0] m;
	signal_mixer_pkg::control_t c;
	signal_mixer_pkg::sources_t s;
	signal_mixer_pkg::pin_release_t rel;
	int failures, checks, cyc;
	signal_mixer i_signal_mixer (.clock(clock), .reset(reset),
		.clock_enable(clock_enable), .control(c), .sources(s),
		.mixed_output_pin(pin), .mixed_output_status(st),
		.keying_status(ks), .high_carrier_in_use(hu), .pin_release(rel));
	line_receiver i_line_receiver (.clock(clock), .reset(reset),
		.line(pin), .level_q(seen));
	// compare and count
	task automatic chk(input string n, input logic e, input logic g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("BAD %s expected %b seen %b", n, e, g);
		end
	endtask
	// let n edges pass, inputs then change 1 ns after
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic final_report;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// hang guard, far above the 89 cycles needed
	always @(posedge clock) begin
		cyc++;
		if (cyc == 2000) begin
			failures++;
			final_report;
		end
	end
	initial begin
		reset = 1'b1;
		clock_enable = 1'b1;
		c = '0;
		s = '0;
		repeat (16) @(posedge clock);
		#1 reset = 1'b0;
		step(1);
		chk("reset", 1'b0, |{pin, st, ks, hu, rel});
		// selections stored while disabled act once enabled
		c.keying_source_select = 4'h1;
		c.high_carrier_select = 4'h1;
		c.low_carrier_select = 4'h2;
		c.mixed_pin_output_enable = 1'b1;
		s.external_keying_pin = 1'b1;
		s.external_carrier_pin_one = 1'b1;
		step(1);
		chk("off", 1'b0, pin);
		c.mixer_enable = 1'b1;
		step(1);
		chk("on", 1'b1, pin);
		step(1);
		chk("far end", 1'b1, seen);
		chk("key level", 1'b1, ks);
		chk("pin copy", 1'b1, st);
		c.mixed_pin_output_enable = 1'b0;
		step(1);
		chk("gate", 1'b0, pin);
		c.mixed_pin_output_enable = 1'b1;
		c.output_invert = 1'b1;
		step(1);
		chk("invert", 1'b0, pin);
		c.output_invert = 1'b0;
		$display("test enable done");
		// each keying code picks exactly its own source
		c.low_carrier_select = 4'h0;
		s.spi_mode = 1'b1;
		for (int k = 0; k < 16; k++) begin
			v = k inside {0, 1, 2, 6, 8, 10};
			m = 4'(k);
			c.keying_source_select = m;
			c.software_keying_value = !v || k == 0;
			s.external_keying_pin = !v || k == 1;
			s.pwm_out = !v || k == 2;
			s.comparator_out = !v || k == 6;
			s.spi_data_out = !v || k == 8;
			s.uart_tx = !v || k == 10;
			step(1);
			chk("key code", v, pin);
		end
		c.keying_source_select = 4'h8;
		s.spi_mode = 1'b0;
		step(1);
		chk("spi off", 1'b0, pin);
		$display("test keying done");
		// carrier codes, low side then high side
		c.keying_source_select = 4'h0;
		for (int k = 0; k < 32; k++) begin
			m = k[3:0];
			v = m inside {1, 2, 3, 4};
			c.software_keying_value = k[4];
			c.high_carrier_select = k[4] ? m : 4'h0;
			c.low_carrier_select = k[4] ? 4'h0 : m;
			s.external_carrier_pin_one = !v || m == 4'h1;
			s.external_carrier_pin_two = !v || m == 4'h2;
			s.refclk_out = !v || m == 4'h3;
			s.pwm_out = !v || m == 4'h4;
			step(1);
			chk("carrier", v, pin);
		end
		c.high_carrier_select = 4'h0;
		c.high_carrier_invert = 1'b1;
		c.software_keying_value = 1'b1;
		step(1);
		chk("high inv", 1'b1, pin);
		c.software_keying_value = 1'b0;
		step(1);
		chk("low plain", 1'b0, pin);
		$display("test carrier done");
		// high sync holds the pulse in flight
		c.high_carrier_invert = 1'b0;
		c.high_carrier_select = 4'h1;
		c.low_carrier_select = 4'h2;
		c.high_carrier_sync_enable = 1'b1;
		c.software_keying_value = 1'b1;
		s = '0;
		s.external_carrier_pin_one = 1'b1;
		step(2);
		chk("high use", 1'b1, hu);
		c.software_keying_value = 1'b0;
		step(1);
		chk("hold", 1'b1, pin);
		s.external_carrier_pin_one = 1'b0;
		s.external_carrier_pin_two = 1'b1;
		step(2);
		chk("swap", 1'b1, pin);
		chk("low use", 1'b0, hu);
		// only the low side synced: leaving high is immediate
		c.high_carrier_sync_enable = 1'b0;
		c.low_carrier_sync_enable = 1'b1;
		c.software_keying_value = 1'b1;
		s.external_carrier_pin_one = 1'b1;
		s.external_carrier_pin_two = 1'b0;
		step(2);
		c.software_keying_value = 1'b0;
		step(1);
		chk("no hold", 1'b0, pin);
		$display("test sync done");
		// pin release follows the disconnect bits
		c.high_carrier_select = 4'h4;
		c.high_carrier_pin_disconnect = 1'b1;
		c.keying_source_select = 4'ha;
		c.keying_source_pin_disconnect = 1'b1;
		c.low_carrier_select = 4'h3;
		c.low_carrier_pin_disconnect = 1'b1;
		step(2);
		chk("rel pwm", 1'b1, rel.pwm);
		chk("rel uart", 1'b1, rel.uart);
		chk("rel refclk", 1'b1, rel.refclk);
		c.mixer_enable = 1'b0;
		step(3);
		chk("rel off", 1'b0, |rel);
		$display("test release done");
		// frozen clock enable ignores control changes
		clock_enable = 1'b0;
		c.mixer_enable = 1'b1;
		c.low_carrier_sync_enable = 1'b0;
		c.keying_source_select = 4'h0;
		c.software_keying_value = 1'b1;
		c.high_carrier_select = 4'h1;
		step(2);
		chk("frozen", 1'b0, pin);
		clock_enable = 1'b1;
		step(1);
		chk("thawed", 1'b1, pin);
		$display("test freeze done");
		final_report;
	end
endmodule // tb_top
`default_nettype wire
